// ### rtl/rmsl_consts.svh
// Purpose: Offsets, field positions, reset values and keys of the remap block.
// Assumes: Word-aligned registers on a 32-bit classic Wishbone bus.
// Notes:   Pins are grouped eight to a group; selector codes above 7 are reserved.
`ifndef RMSL_CONSTS_SVH
`define RMSL_CONSTS_SVH
`define RMSL_OUT_SEL_BASE   8'h00
`define RMSL_IN_SEL_BASE    8'h20
`define RMSL_CFG_CTRL_ADR   8'h40
`define RMSL_UNLOCK_ADR     8'h41
`define RMSL_STATUS_ADR     8'h42
`define RMSL_LOCK_BIT       13
`define RMSL_ONE_SHOT_BIT   29
`define RMSL_SEL_RESET      4'h0
`define RMSL_UNLOCK_KEY1    32'h5A5A0F0F
`define RMSL_UNLOCK_KEY2    32'hA5A5F0F0
`define RMSL_SRC_NONE       4'h0
`define RMSL_SRC_UART1_TX   4'h1
`define RMSL_SRC_UART2_TX   4'h2
`define RMSL_SRC_UART1_RTS  4'h3
`define RMSL_SRC_UART2_RTS  4'h4
`define RMSL_SRC_SPI1_SEL   4'h5
`define RMSL_SRC_SPI2_SEL   4'h6
`define RMSL_SRC_SPI1_DATA  4'h7
`define RMSL_SRC_SPI2_DATA  4'h8
`define RMSL_SRC_COMPARE1   4'h9
`define RMSL_SRC_COMPARE2   4'hA
`define RMSL_SRC_COMPARE3   4'hB
`define RMSL_SRC_COMPARE4   4'hC
`define RMSL_SRC_COMPARE5   4'hD
`define RMSL_SRC_CMP1       4'hE
`define RMSL_SRC_CMP2       4'hF
`endif

// ### rtl/rmsl_pkg.sv
// Purpose: Types shared by the remap block.
// Assumes: Constants come from rmsl_consts.svh.
// Notes:   The unlock walk is one-hot.
package rmsl_pkg;
	typedef logic [3:0] rmsl_sel_t;
	typedef enum logic [2:0] {
		RMSL_IDLE     = 3'b001,
		RMSL_KEY_SEEN = 3'b010,
		RMSL_OPEN     = 3'b100
	} rmsl_unlock_e;
endpackage

// ### rtl/rmsl_top.sv
// Purpose: Pin remapping with output and input selectors and a write lock.
// Assumes: Classic Wishbone slave, 32-bit data, word index on wb_adr_i[9:2].
// Notes:   Pin and peripheral-input outputs are registered, one cycle behind selectors.
// Summary of operation
// (R1) Locked selector writes are acked normally but change nothing.
// (R2) Lock is config bit 13; set blocks selector writes, clear allows them.
// (R3) The lock bit changes only right after the two-key unlock sequence.
// (R4) One-shot config set: once locked, lock cannot clear and unlock is ignored.
// (R5) With one-shot active only reset clears the lock.
// (R6) Unprogrammed config word reads bit 29 as one, so one-shot is active.
// (R7) Output selector is bits 3:0; code 0000 connects nothing.
// (R8) First pin group decodes uart1 tx, uart2 rts, spi1 select, compare 1, comparator 2.
// (R9) Second group decodes spi1 data, spi2 data, compare 2, comparator 3.
// (R10) Third group decodes spi1/spi2 data, compare 4, compare 5, reference clock.
// (R11) Fourth group decodes uart1 rts, uart2 tx, spi2 select, compare 3, comparator 1.
// (R12) All output selectors reset to zero, so pins start disconnected.
// (R13) Peripheral input selectors are 4-bit and share the same lock.
// (R14) A mapped peripheral beats other digital pin use, never an analog function.
// (R15) Reserved output codes behave like code zero.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "rmsl_consts.svh"
`default_nettype none
module rmsl_top
	import rmsl_pkg::*;
#(
	parameter int NPINS = 32, // Remappable pins.
	parameter int NINS  = 24  // Remappable peripheral inputs.
) (
	input  wire logic              mclk,                 // System clock, 50 MHz.
	input  wire logic              reset,                // Synchronous reset, active high.
	input  wire logic              wb_cyc_i,             // Bus cycle.
	input  wire logic              wb_stb_i,             // Bus strobe.
	input  wire logic              wb_we_i,              // Write enable.
	input  wire logic [31:0]       wb_adr_i,             // Byte address.
	input  wire logic [3:0]        wb_sel_i,             // Byte lanes.
	input  wire logic [31:0]       wb_dat_i,             // Write data.
	output logic      [31:0]       wb_dat_o,             // Read data.
	output logic                   wb_ack_o,             // Acknowledge.
	input  wire logic [31:0]       device_cfg_word_three,// Configuration word three.
	input  wire logic              uart1_tx_out,         // Peripheral output.
	input  wire logic              uart2_tx_out,         // Peripheral output.
	input  wire logic              uart1_rts_out,        // Peripheral output.
	input  wire logic              uart2_rts_out,        // Peripheral output.
	input  wire logic              spi1_select_out,      // Peripheral output.
	input  wire logic              spi2_select_out,      // Peripheral output.
	input  wire logic              spi1_data_out,        // Peripheral output.
	input  wire logic              spi2_data_out,        // Peripheral output.
	input  wire logic              compare_out_1,        // Peripheral output.
	input  wire logic              compare_out_2,        // Peripheral output.
	input  wire logic              compare_out_3,        // Peripheral output.
	input  wire logic              compare_out_4,        // Peripheral output.
	input  wire logic              compare_out_5,        // Peripheral output.
	input  wire logic              comparator_out_1,     // Peripheral output.
	input  wire logic              comparator_out_2,     // Peripheral output.
	input  wire logic              comparator_out_3,     // Peripheral output.
	input  wire logic              reference_clock_out,  // Peripheral output.
	input  wire logic [NPINS-1:0]  gpio_o,               // Ordinary digital pin data.
	input  wire logic [NPINS-1:0]  gpio_oe_n,            // Ordinary digital enable, low drives.
	input  wire logic [NPINS-1:0]  analog_en,            // Pin in analog use.
	input  wire logic [NPINS-1:0]  pin_i,                // Pin levels.
	output logic      [NPINS-1:0]  pin_o,                // Pin drive data.
	output logic      [NPINS-1:0]  pin_oe_n,             // Pin enable, low drives.
	output logic      [NINS-1:0]   periph_in,            // Remapped peripheral inputs.
	output logic                   map_lock_bit          // Current lock state.
);

	rmsl_sel_t    out_sel [NPINS];
	rmsl_sel_t    next_out_sel [NPINS];
	rmsl_sel_t    in_sel [NINS];
	rmsl_sel_t    next_in_sel [NINS];
	rmsl_unlock_e ust;
	rmsl_unlock_e next_ust;
	logic         next_lock;
	logic         next_ack;
	logic [31:0]  next_dat;
	logic [NPINS-1:0] next_pin_o;
	logic [NPINS-1:0] next_pin_oe_n;
	logic [NINS-1:0]  next_periph_in;
	logic         one_shot_lock_cfg;
	logic         acc;
	logic [7:0]   widx;
	logic [15:0]  srcs;

	// Peripheral input group: five, six, eight and five inputs per pin group.
	function automatic logic [1:0] in_group(input int j);
		if (j < 5)
			return 2'd0;
		else if (j < 11)
			return 2'd1;
		else if (j < 19)
			return 2'd2;
		else
			return 2'd3;
	endfunction

	// Source index for a pin group and selector code; NONE for null or reserved.
	function automatic logic [3:0] out_src(input logic [1:0] grp, input rmsl_sel_t code);
		logic [3:0] s;
		s = `RMSL_SRC_NONE;
		case (grp)
			2'd0: begin
				case (code)
					4'h1: s = `RMSL_SRC_UART1_TX;   // R8
					4'h2: s = `RMSL_SRC_UART2_RTS;
					4'h3: s = `RMSL_SRC_SPI1_SEL;
					4'h5: s = `RMSL_SRC_COMPARE1;
					4'h7: s = `RMSL_SRC_CMP2;
					default: s = `RMSL_SRC_NONE; // R7 R15
				endcase
			end
			2'd1: begin
				case (code)
					4'h3: s = `RMSL_SRC_SPI1_DATA;   // R9
					4'h4: s = `RMSL_SRC_SPI2_DATA;
					4'h5: s = `RMSL_SRC_COMPARE2;
					4'h7: s = 4'h0;
					default: s = `RMSL_SRC_NONE; // R15
				endcase
			end
			2'd2: begin
				case (code)
					4'h3: s = `RMSL_SRC_SPI1_DATA;   // R10
					4'h4: s = `RMSL_SRC_SPI2_DATA;
					4'h5: s = `RMSL_SRC_COMPARE4;
					4'h6: s = `RMSL_SRC_COMPARE5;
					4'h7: s = 4'h0;
					default: s = `RMSL_SRC_NONE; // R15
				endcase
			end
			default: begin
				case (code)
					4'h1: s = `RMSL_SRC_UART1_RTS;  // R11
					4'h2: s = `RMSL_SRC_UART2_TX;
					4'h4: s = `RMSL_SRC_SPI2_SEL;
					4'h5: s = `RMSL_SRC_COMPARE3;
					4'h7: s = `RMSL_SRC_CMP1;
					default: s = `RMSL_SRC_NONE; // R15
				endcase
			end
		endcase
		return s;
	endfunction

	// Codes 0111 of groups two and three carry sources outside the 4-bit index.
	function automatic logic extra_src(input logic [1:0] grp, input rmsl_sel_t code);
		return (code == 4'h7) && (grp == 2'd1 || grp == 2'd2);
	endfunction

	assign one_shot_lock_cfg = device_cfg_word_three[`RMSL_ONE_SHOT_BIT]; // R6
	assign acc  = wb_cyc_i & wb_stb_i & wb_ack_o;
	assign widx = wb_adr_i[9:2];
	assign srcs = {comparator_out_2, comparator_out_1, compare_out_5, compare_out_4,
		compare_out_3, compare_out_2, compare_out_1, spi2_data_out, spi1_data_out,
		spi2_select_out, spi1_select_out, uart2_rts_out, uart1_rts_out, uart2_tx_out,
		uart1_tx_out, 1'b0};

	// Bus slave, selectors and the lock.
	always_comb begin
		next_out_sel = out_sel;
		next_in_sel  = in_sel;
		next_lock    = map_lock_bit;
		next_ust     = ust;
		next_ack     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		next_dat     = wb_dat_o;
		if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			next_dat = 32'h00000000;
			if (widx < `RMSL_OUT_SEL_BASE + 8'(NPINS))
				next_dat[3:0] = out_sel[widx[4:0]];
			else if (widx >= `RMSL_IN_SEL_BASE && widx < `RMSL_IN_SEL_BASE + 8'(NINS))
				next_dat[3:0] = in_sel[5'(widx - `RMSL_IN_SEL_BASE)];
			else if (widx == `RMSL_CFG_CTRL_ADR)
				next_dat[`RMSL_LOCK_BIT] = map_lock_bit;
			else if (widx == `RMSL_STATUS_ADR)
				next_dat[1:0] = {one_shot_lock_cfg, ust == RMSL_OPEN};
		end
		if (acc && wb_we_i) begin
			if (widx < `RMSL_OUT_SEL_BASE + 8'(NPINS)) begin
				if (!map_lock_bit && wb_sel_i[0]) // R1 R2
					next_out_sel[widx[4:0]] = wb_dat_i[3:0];
			end else if (widx >= `RMSL_IN_SEL_BASE && widx < `RMSL_IN_SEL_BASE + 8'(NINS)) begin
				if (!map_lock_bit && wb_sel_i[0]) // R13
					next_in_sel[5'(widx - `RMSL_IN_SEL_BASE)] = wb_dat_i[3:0];
			end else if (widx == `RMSL_CFG_CTRL_ADR) begin
				if (ust == RMSL_OPEN && wb_sel_i[1]) begin // R3
					if (!(map_lock_bit && one_shot_lock_cfg)) // R4 R5
						next_lock = wb_dat_i[`RMSL_LOCK_BIT];
				end
				next_ust = RMSL_IDLE;
			end else if (widx == `RMSL_UNLOCK_ADR) begin
				if (map_lock_bit && one_shot_lock_cfg) // R4
					next_ust = RMSL_IDLE;
				else begin
					case (ust)
						RMSL_IDLE:
							next_ust = (wb_dat_i == `RMSL_UNLOCK_KEY1) ? RMSL_KEY_SEEN : RMSL_IDLE;
						RMSL_KEY_SEEN:
							next_ust = (wb_dat_i == `RMSL_UNLOCK_KEY2) ? RMSL_OPEN : RMSL_IDLE;
						RMSL_OPEN:
							next_ust = (wb_dat_i == `RMSL_UNLOCK_KEY1) ? RMSL_KEY_SEEN : RMSL_IDLE;
						default:
							next_ust = RMSL_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < NPINS; i++)
				out_sel[i] <= `RMSL_SEL_RESET; // R12
			for (int j = 0; j < NINS; j++)
				in_sel[j] <= `RMSL_SEL_RESET;
			map_lock_bit <= 1'b0; // R5
			ust          <= RMSL_IDLE;
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h00000000;
		end else begin
			out_sel      <= next_out_sel;
			in_sel       <= next_in_sel;
			map_lock_bit <= next_lock;
			ust          <= next_ust;
			wb_ack_o     <= next_ack;
			wb_dat_o     <= next_dat;
		end
	end

	// Pin and peripheral-input steering.
	always_comb begin
		logic [3:0] s;
		logic [1:0] g;
		s = 4'h0;
		g = 2'd0;
		next_pin_o     = gpio_o;
		next_pin_oe_n  = gpio_oe_n;
		next_periph_in = '0;
		for (int p = 0; p < NPINS; p++) begin
			g = 2'(p / 8);
			s = out_src(g, out_sel[p]);
			if (analog_en[p]) begin // R14
				next_pin_o[p]    = 1'b0;
				next_pin_oe_n[p] = 1'b1;
			end else if (extra_src(g, out_sel[p])) begin
				next_pin_o[p]    = (g == 2'd1) ? comparator_out_3 : reference_clock_out;
				next_pin_oe_n[p] = 1'b0;
			end else if (s != `RMSL_SRC_NONE) begin // R14
				next_pin_o[p]    = srcs[s];
				next_pin_oe_n[p] = 1'b0;
			end
		end
		for (int j = 0; j < NINS; j++) begin
			if (in_sel[j] < 4'h8) // R13
				next_periph_in[j] = pin_i[{in_group(j), in_sel[j][2:0]}];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_o     <= '0;
			pin_oe_n  <= '1;
			periph_in <= '0;
		end else begin
			pin_o     <= next_pin_o;
			pin_oe_n  <= next_pin_oe_n;
			periph_in <= next_periph_in;
		end
	end

	sequence s_sel_write(logic [7:0] idx);
		acc && wb_we_i && widx == idx && wb_sel_i[0];
	endsequence

	sequence s_cfg_write;
		acc && wb_we_i && widx == `RMSL_CFG_CTRL_ADR && wb_sel_i[1];
	endsequence

	a_locked_out_write: assert property (@(posedge mclk) disable iff (reset) // R1
		s_sel_write(8'h03) and map_lock_bit |=> $stable(out_sel[3]))
		else $error("Locked selector write changed the selector.");

	a_open_out_write: assert property (@(posedge mclk) disable iff (reset) // R2
		s_sel_write(8'h00) and !map_lock_bit |=> out_sel[0] == $past(wb_dat_i[3:0]))
		else $error("Unlocked selector write was not stored.");

	a_lock_needs_key: assert property (@(posedge mclk) disable iff (reset) // R3
		s_cfg_write and ust != RMSL_OPEN |=> $stable(map_lock_bit))
		else $error("Lock changed without the unlock sequence.");

	a_one_shot_hold: assert property (@(posedge mclk) disable iff (reset) // R4
		map_lock_bit && one_shot_lock_cfg |=> map_lock_bit)
		else $error("One-shot lock was cleared.");

	a_reset_clears: assert property (@(posedge mclk) // R5
		reset |=> !map_lock_bit && out_sel[0] == 4'h0 && out_sel[31] == 4'h0)
		else $error("Reset left lock or selectors set.");

	a_one_shot_key: assert property (@(posedge mclk) disable iff (reset) // R6
		acc && wb_we_i && widx == `RMSL_UNLOCK_ADR && map_lock_bit
		&& device_cfg_word_three[29] |=> ust == RMSL_IDLE)
		else $error("Unlock proceeded under one-shot lock.");

	a_null_output: assert property (@(posedge mclk) disable iff (reset) // R7
		out_sel[0] == 4'h0 && !analog_en[0] |=> pin_oe_n[0] == $past(gpio_oe_n[0]))
		else $error("Null code drove a peripheral.");

	a_group1_uart: assert property (@(posedge mclk) disable iff (reset) // R8
		out_sel[0] == 4'h1 && !analog_en[0] |=> !pin_oe_n[0] && pin_o[0] == $past(uart1_tx_out))
		else $error("Group one code 1 did not route uart1 transmit.");

	a_group2_cmp: assert property (@(posedge mclk) disable iff (reset) // R9
		out_sel[8] == 4'h7 && !analog_en[8] |=> !pin_oe_n[8] && pin_o[8] == $past(comparator_out_3))
		else $error("Group two code 7 did not route comparator 3.");

	a_group3_ref: assert property (@(posedge mclk) disable iff (reset) // R10
		out_sel[16] == 4'h7 && !analog_en[16] |=> pin_o[16] == $past(reference_clock_out))
		else $error("Group three code 7 did not route the reference clock.");

	a_group4_ss2: assert property (@(posedge mclk) disable iff (reset) // R11
		out_sel[24] == 4'h4 && !analog_en[24] |=> pin_o[24] == $past(spi2_select_out))
		else $error("Group four code 4 did not route spi2 select.");

	a_locked_in_write: assert property (@(posedge mclk) disable iff (reset) // R13
		s_sel_write(`RMSL_IN_SEL_BASE + 8'h05) and map_lock_bit |=> $stable(in_sel[5]))
		else $error("Locked input selector write changed it.");

	a_input_follows: assert property (@(posedge mclk) disable iff (reset) // R13
		in_sel[5] == 4'h3 |=> periph_in[5] == $past(pin_i[11]))
		else $error("Peripheral input did not follow its selected pin.");

	a_analog_wins: assert property (@(posedge mclk) disable iff (reset) // R14
		analog_en[1] |=> pin_oe_n[1])
		else $error("Pin driven while in analog use.");

	a_reserved_null: assert property (@(posedge mclk) disable iff (reset) // R15
		out_sel[1] == 4'h9 && !analog_en[1] |=> pin_oe_n[1] == $past(gpio_oe_n[1]))
		else $error("Reserved code drove a peripheral.");

	a_ack_follows: assert property (@(posedge mclk) disable iff (reset) // R1
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus request was not acknowledged.");

	a_ack_one: assert property (@(posedge mclk) disable iff (reset)
		wb_ack_o |=> !wb_ack_o)
		else $error("Acknowledge held for two cycles.");

endmodule
`default_nettype wire

// ### dv/rmsl_periph_model.sv
// Purpose: Far side of the remap block: peripheral outputs and pad levels.
// Assumes: Peripherals are clocked logic that change just after an edge.
// Notes:   An undriven pad shows the outside level given by the bench.
`timescale 1ns/1ps
`default_nettype none
module rmsl_periph_model (
	input  wire logic        mclk,     // System clock.
	input  wire logic [16:0] src_pat,  // Wanted peripheral levels.
	input  wire logic [31:0] ext_lvl,  // Outside level of undriven pads.
	input  wire logic [31:0] pin_o,    // Block pin data.
	input  wire logic [31:0] pin_oe_n, // Block pin enable, low drives.
	output logic      [16:0] periph,   // Peripheral outputs.
	output logic      [31:0] pin_i     // Resolved pad levels.
);
	always_ff @(posedge mclk) begin
		periph <= src_pat;
	end
	// A pad follows the block where it drives and the outside level elsewhere.
	assign pin_i = (pin_o & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule
`default_nettype wire

// ### dv/tb.sv
// Purpose: Self-checking bench for the remap block.
// Assumes: Bus answers within a few cycles; peripheral model adds one cycle.
// Notes:   Pin index p carries code p mod 8, then a reserved code.
`timescale 1ns/1ps
`include "rmsl_consts.svh"
`default_nettype none
module tb;
	logic        mclk = 1'b0, reset = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, dev_cfg = 32'hFFFFFFFF;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] gpio_o = 32'hFFFFFFFF, gpio_oe_n = 32'hFFFFFFFF, analog_en = 32'h0;
	logic [31:0] ext_lvl = 32'h0;
	logic [16:0] src_pat = 17'h0, periph;
	logic [31:0] wb_dat_o, pin_i, pin_o, pin_oe_n;
	logic [23:0] periph_in;
	logic        wb_ack_o, map_lock_bit;
	int          failures = 0, n_checks = 0;
	localparam logic [4:0] NC = 5'h1F;
	logic [4:0]  src_tab [0:31] = '{NC, 5'h00, 5'h03, 5'h04, NC, 5'h08, NC, 5'h0E,
		NC, NC, NC, 5'h06, 5'h07, 5'h09, NC, 5'h0F, NC, NC, NC, 5'h06, 5'h07, 5'h0B, 5'h0C,
		5'h10, NC, 5'h02, 5'h01, NC, 5'h05, 5'h0A, NC, 5'h0D};
	always #10 mclk = ~mclk;
	rmsl_periph_model u_rmsl_periph_model (.mclk(mclk), .src_pat(src_pat), .ext_lvl(ext_lvl),
		.pin_o(pin_o), .pin_oe_n(pin_oe_n), .periph(periph), .pin_i(pin_i));
	rmsl_top u_rmsl_top (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .device_cfg_word_three(dev_cfg),
		.uart1_tx_out(periph[0]), .uart2_tx_out(periph[1]), .uart1_rts_out(periph[2]),
		.uart2_rts_out(periph[3]), .spi1_select_out(periph[4]), .spi2_select_out(periph[5]),
		.spi1_data_out(periph[6]), .spi2_data_out(periph[7]), .compare_out_1(periph[8]),
		.compare_out_2(periph[9]), .compare_out_3(periph[10]), .compare_out_4(periph[11]),
		.compare_out_5(periph[12]), .comparator_out_1(periph[13]),
		.comparator_out_2(periph[14]), .comparator_out_3(periph[15]),
		.reference_clock_out(periph[16]), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n),
		.analog_en(analog_en), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.periph_in(periph_in), .map_lock_bit(map_lock_bit));
	function automatic logic [31:0] adr(input logic [7:0] w);
		return {22'h0, w, 2'b00};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %b", $time, what, got);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask
	task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s,
		output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		chk_bit(wb_ack_o, 1'b1, "bus answer");
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		wb(1'b1, a, d, 4'hF, q);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, 4'hF, q);
	endtask
	task automatic unlock();
		wr(adr(`RMSL_UNLOCK_ADR), `RMSL_UNLOCK_KEY1);
		wr(adr(`RMSL_UNLOCK_ADR), `RMSL_UNLOCK_KEY2);
	endtask
	task automatic set_lock(input logic v);
		logic [31:0] q;
		wb(1'b1, adr(`RMSL_CFG_CTRL_ADR), 32'(v) << `RMSL_LOCK_BIT, 4'h2, q);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		rd(adr(`RMSL_OUT_SEL_BASE), q);
		chk_word(q, 32'h0, "first selector");
		rd(adr(`RMSL_OUT_SEL_BASE + 8'h1F), q);
		chk_word(q, 32'h0, "last selector");
		chk_word(pin_oe_n, 32'hFFFFFFFF, "pins idle");
		chk_bit(map_lock_bit, 1'b0, "lock at start");
		rd(32'h000003FC, q);
		chk_word(q, 32'h0, "unmapped read");
	endtask
	task automatic t_in_map();
		wr(adr(`RMSL_IN_SEL_BASE + 8'h05), 32'h3);
		ext_lvl <= 32'h00000800;
		tick(3);
		chk_bit(periph_in[5], 1'b1, "input high");
		ext_lvl <= 32'hFFFFF7FF;
		tick(3);
		chk_bit(periph_in[5], 1'b0, "input low");
		wr(adr(`RMSL_IN_SEL_BASE + 8'h05), 32'h8);
		ext_lvl <= 32'hFFFFFFFF;
		tick(3);
		chk_bit(periph_in[5], 1'b0, "reserved input");
		wr(adr(`RMSL_IN_SEL_BASE + 8'h05), 32'h3);
	endtask
	task automatic t_out_map();
		logic [31:0] q, code;
		logic [4:0]  s;
		gpio_oe_n <= 32'hAAAAAAAA;
		for (int p = 0; p < 32; p++) begin
			for (int r = 0; r < 2; r++) begin
				code = {28'h0, 1'(r), 3'(p)};
				s = (r == 1) ? NC : src_tab[p];
				wr(adr(`RMSL_OUT_SEL_BASE + 8'(p)), code);
				rd(adr(`RMSL_OUT_SEL_BASE + 8'(p)), q);
				chk_word(q, code, "selector readback");
				src_pat <= 17'h1 << s;
				tick(3);
				chk_bit(pin_oe_n[p], s == NC && p % 2 == 1, "pin driven");
				chk_bit(pin_o[p], 1'b1, "pin high");
				src_pat <= ~(17'h1 << s);
				tick(3);
				chk_bit(pin_o[p], s == NC, "pin low");
			end
		end
	endtask
	task automatic t_analog();
		wr(adr(`RMSL_OUT_SEL_BASE + 8'h01), 32'h1);
		src_pat <= 17'h1;
		analog_en <= 32'h2;
		tick(3);
		chk_bit(pin_oe_n[1], 1'b1, "analog enable");
		chk_bit(pin_o[1], 1'b0, "analog data");
		analog_en <= 32'h0;
	endtask
	task automatic t_lock();
		logic [31:0] q;
		dev_cfg <= 32'h0;
		set_lock(1'b1);
		chk_bit(map_lock_bit, 1'b0, "lock without key");
		unlock();
		set_lock(1'b1);
		chk_bit(map_lock_bit, 1'b1, "lock set");
		wr(adr(`RMSL_OUT_SEL_BASE + 8'h03), 32'h5);
		rd(adr(`RMSL_OUT_SEL_BASE + 8'h03), q);
		chk_word(q, 32'hB, "locked out selector");
		wr(adr(`RMSL_IN_SEL_BASE + 8'h05), 32'h2);
		rd(adr(`RMSL_IN_SEL_BASE + 8'h05), q);
		chk_word(q, 32'h3, "locked in selector");
		unlock();
		set_lock(1'b0);
		chk_bit(map_lock_bit, 1'b0, "lock cleared");
		wr(adr(`RMSL_OUT_SEL_BASE + 8'h03), 32'h5);
		rd(adr(`RMSL_OUT_SEL_BASE + 8'h03), q);
		chk_word(q, 32'h5, "open selector");
		dev_cfg <= 32'hFFFFFFFF;
		unlock();
		set_lock(1'b1);
		unlock();
		rd(adr(`RMSL_STATUS_ADR), q);
		chk_bit(q[0], 1'b0, "unlock ignored");
		chk_bit(q[1], 1'b1, "one-shot seen");
		set_lock(1'b0);
		chk_bit(map_lock_bit, 1'b1, "one-shot hold");
		reset <= 1'b1;
		tick(2);
		reset <= 1'b0;
		tick(1);
		chk_bit(map_lock_bit, 1'b0, "lock after reset");
		rd(adr(`RMSL_OUT_SEL_BASE + 8'h03), q);
		chk_word(q, 32'h0, "selector after reset");
	endtask
	task automatic tally_and_finish();
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		failures++;
		$display("unexpected at %0t: watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_in_map();
		t_out_map();
		t_analog();
		t_lock();
		tally_and_finish();
	end
endmodule
`default_nettype wire
